/* shared/ifcm_cfg.svh */
// timing figures and fixed layout values of the fieldbus cycle master
`ifndef IFCM_CFG_SVH
`define IFCM_CFG_SVH

// core clock
`define IFCM_CLK_NS          50
// width of every cycle-time compare value
`define IFCM_TW              16
// width of the slave index
`define IFCM_AW              7
// sync broadcast frame length on the wire
`define IFCM_SYNC_NS         4000
// one frame segment (header, parameter area, process data, trailer)
`define IFCM_SEG_NS          1000
// one acyclic service slot
`define IFCM_ACYC_NS         8000
// new-station admission window
`define IFCM_GAP_NS          2000
// token pass
`define IFCM_TOKEN_NS        1000
// interval between self token passes in the reserve
`define IFCM_PAUSE_NS        3000
// derived cycle counts, least times rounded up
`define IFCM_CYC(ns)         (((ns) + `IFCM_CLK_NS - 1) / `IFCM_CLK_NS)

`endif

/* shared/ifcm_pkg.sv */
// types shared by the fieldbus cycle master
`include "ifcm_cfg.svh"
package ifcm_pkg;

  // phases of one equidistant bus cycle
  typedef enum logic [2:0] {
    PH_IDLE, PH_SYNC, PH_EXCH, PH_ACYC, PH_GAP, PH_TOKEN, PH_RESERVE
  } ifcm_phase_t;

  // parts of one cyclic frame
  typedef enum logic [1:0] {
    SEG_HEADER, SEG_PARAM, SEG_PROCESS, SEG_TRAILER
  } ifcm_seg_t;

  // bus role of a port
  typedef enum logic {
    ROLE_MASTER, ROLE_SLAVE
  } ifcm_role_t;

  // compare points, all counted in core cycles from cycle start
  typedef struct packed {
    logic [`IFCM_TW-1:0] bus_cycle_time;      // cycle length
    logic [`IFCM_TW-1:0] master_time;         // controller start offset
    logic [`IFCM_TW-1:0] input_latch_instant;
    logic [`IFCM_TW-1:0] output_accept_instant;
    logic [`IFCM_TW-1:0] token_hold_limit;
  } ifcm_cfg_t;

  // timing strobes, one cycle each
  typedef struct packed {
    logic cycle_start;       // also the position-control clock
    logic input_latch;
    logic controller_start;
    logic output_accept;
  } ifcm_strobe_t;

  // frame activity toward the drive bus
  typedef struct packed {
    ifcm_phase_t         phase;
    ifcm_seg_t           seg;
    logic [`IFCM_AW-1:0] slave_idx;
    logic                to_slave;   // 1: control words and setpoints out
    logic                setpoints;  // fresh setpoints carried this exchange
    logic                token_self; // token passed to ourselves
    logic                token_peer; // token passed to another master
  } ifcm_bus_t;

endpackage : ifcm_pkg

/* src/ifcm_cycle_master.sv */
// isochronous cycle scheduler for the drive-side fieldbus master
`timescale 1ns/1ps
`include "ifcm_cfg.svh"

// Operation
// - drive bus port is always bus master
// - position-control clock comes from bus cycle
// - plc bus port selectable master or slave
// - every slave served in every fixed cycle that overrun does not cut
// - sync broadcast frame sent every cycle
// - frame: header, parameter area, process data, trailer
// - out control and setpoints, in status and actuals
// - controller starts at master time after exchange
// - new setpoints sent in next exchange
// - application cycle equals bus cycle
// - acyclic service only within token hold limit
// - gap phase admits new active stations
// - token phase passes token to self or peer
// - reserve passes token to self until cycle ends
module ifcm_cycle_master #(
  parameter int NSLAVE = 3  // slaves on the drive bus
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // configuration, held stable while running
  input  wire logic                 run,
  input  wire ifcm_pkg::ifcm_cfg_t  cfg,
  input  wire ifcm_pkg::ifcm_role_t plc_role_sel,
  // requests from the controller side
  input  wire logic                 acyc_req,
  input  wire logic                 peer_master,
  input  wire logic                 setpoints_done,
  // port roles and drive bus activity
  output ifcm_pkg::ifcm_role_t      drive_role,
  output ifcm_pkg::ifcm_role_t      plc_role,
  output ifcm_pkg::ifcm_bus_t       bus,
  output logic                      sync_frame,
  output logic                      acyc_active,
  output logic                      gap_active,
  // timing strobes
  output ifcm_pkg::ifcm_strobe_t    strobe,
  // faults
  output logic                      overrun,
  output logic                      order_fault
);

  localparam int TW = `IFCM_TW;
  localparam int AW = `IFCM_AW;
  // phase lengths in cycles
  localparam logic [TW-1:0] SYNC_CYC  = TW'(`IFCM_CYC(`IFCM_SYNC_NS));
  localparam logic [TW-1:0] SEG_CYC   = TW'(`IFCM_CYC(`IFCM_SEG_NS));
  localparam logic [TW-1:0] ACYC_CYC  = TW'(`IFCM_CYC(`IFCM_ACYC_NS));
  localparam logic [TW-1:0] GAP_CYC   = TW'(`IFCM_CYC(`IFCM_GAP_NS));
  localparam logic [TW-1:0] TOKEN_CYC = TW'(`IFCM_CYC(`IFCM_TOKEN_NS));
  localparam logic [TW-1:0] PAUSE_CYC = TW'(`IFCM_CYC(`IFCM_PAUSE_NS));
  localparam logic [AW-1:0] LAST_SLV  = AW'(NSLAVE - 1);

  // refuse slave counts the index cannot hold
  if (NSLAVE < 1 || NSLAVE > (1 << AW)) begin : g_bad_nslave
    $error("NSLAVE out of range for the slave index width");
  end

  // whole state in one register
  typedef struct packed {
    ifcm_pkg::ifcm_role_t   plc_role;
    ifcm_pkg::ifcm_bus_t    bus;
    ifcm_pkg::ifcm_strobe_t strobe;
    logic [TW-1:0]          cyc_cnt;   // position inside the bus cycle
    logic [TW-1:0]          slot_cnt;  // position inside the current phase slot
    logic                   exch_done; // exchange window over this cycle
    logic                   ctrl_armed;
    logic                   sp_pending; // setpoints computed, not yet sent
    logic                   sync_frame;
    logic                   acyc;
    logic                   gap;
    logic                   overrun;
    logic                   order_fault;
  } ifcm_state_t;

  ifcm_state_t s;
  ifcm_state_t next_s;

  // next-state logic
  always_comb begin
    logic cyc_end;
    logic slot_end;
    logic go_start;
    cyc_end  = 1'b0;
    slot_end = 1'b0;
    go_start = 1'b0;
    next_s   = s;
    next_s.plc_role       = plc_role_sel;
    next_s.strobe         = '0;
    next_s.bus.token_self = 1'b0;
    next_s.bus.token_peer = 1'b0;
    next_s.slot_cnt       = s.slot_cnt + TW'(1);
    next_s.cyc_cnt        = s.cyc_cnt + TW'(1);
    cyc_end  = (s.cyc_cnt >= cfg.bus_cycle_time - TW'(1));
    // compare against the length of the slot the phase is in
    case (s.bus.phase)
      ifcm_pkg::PH_SYNC:  slot_end = (s.slot_cnt == SYNC_CYC - TW'(1));
      ifcm_pkg::PH_EXCH:  slot_end = (s.slot_cnt == SEG_CYC - TW'(1));
      ifcm_pkg::PH_ACYC:  slot_end = (s.slot_cnt == ACYC_CYC - TW'(1));
      ifcm_pkg::PH_GAP:   slot_end = (s.slot_cnt == GAP_CYC - TW'(1));
      ifcm_pkg::PH_TOKEN: slot_end = (s.slot_cnt == TOKEN_CYC - TW'(1));
      ifcm_pkg::PH_RESERVE: slot_end = (s.slot_cnt == PAUSE_CYC - TW'(1));
      default:            slot_end = 1'b0;
    endcase
    // compare points on the cycle counter
    if (s.bus.phase != ifcm_pkg::PH_IDLE) begin
      if (s.cyc_cnt == cfg.input_latch_instant) begin
        next_s.strobe.input_latch = 1'b1;
      end
      if (s.cyc_cnt == cfg.output_accept_instant) begin
        next_s.strobe.output_accept = 1'b1;
      end
      if (s.cyc_cnt == cfg.master_time) begin
        // controller may only run once the actuals are in
        if (s.exch_done) begin
          next_s.strobe.controller_start = 1'b1;
        end else begin
          next_s.order_fault = 1'b1;
        end
      end
    end
    // freshly computed setpoints wait for the next exchange; set wins
    if (setpoints_done) begin
      next_s.sp_pending = 1'b1;
    end
    // phase sequencing
    case (s.bus.phase)
      ifcm_pkg::PH_IDLE: begin
        next_s.cyc_cnt = '0;
        go_start       = run;
      end
      ifcm_pkg::PH_SYNC: begin
        // broadcast keeps every slave on the equidistant grid
        if (slot_end) begin
          next_s.sync_frame    = 1'b0;
          next_s.bus.phase     = ifcm_pkg::PH_EXCH;
          next_s.bus.seg       = ifcm_pkg::SEG_HEADER;
          next_s.bus.slave_idx = '0;
          next_s.bus.to_slave  = 1'b1;
          next_s.slot_cnt      = '0;
        end
      end
      ifcm_pkg::PH_EXCH: begin
        // poll each slave: request frame out, reply frame in
        if (slot_end) begin
          next_s.slot_cnt = '0;
          if (s.bus.seg != ifcm_pkg::SEG_TRAILER) begin
            next_s.bus.seg = ifcm_pkg::ifcm_seg_t'(s.bus.seg + 2'(1));
          end else if (s.bus.to_slave) begin
            // reply carries status words and actuals
            next_s.bus.to_slave = 1'b0;
            next_s.bus.seg      = ifcm_pkg::SEG_HEADER;
          end else if (s.bus.slave_idx != LAST_SLV) begin
            next_s.bus.slave_idx = s.bus.slave_idx + AW'(1);
            next_s.bus.to_slave  = 1'b1;
            next_s.bus.seg       = ifcm_pkg::SEG_HEADER;
          end else begin
            next_s.exch_done     = 1'b1;
            next_s.bus.setpoints = 1'b0;
            // acyclic slot only while under the hold limit
            if (acyc_req && (s.cyc_cnt + ACYC_CYC < cfg.token_hold_limit)) begin
              next_s.bus.phase = ifcm_pkg::PH_ACYC;
              next_s.acyc      = 1'b1;
            end else begin
              next_s.bus.phase = ifcm_pkg::PH_GAP;
              next_s.gap       = 1'b1;
            end
          end
        end
      end
      ifcm_pkg::PH_ACYC: begin
        if (slot_end) begin
          next_s.acyc      = 1'b0;
          next_s.gap       = 1'b1;
          next_s.bus.phase = ifcm_pkg::PH_GAP;
          next_s.slot_cnt  = '0;
        end
      end
      ifcm_pkg::PH_GAP: begin
        // window for admitting newly appearing active stations
        if (slot_end) begin
          next_s.gap       = 1'b0;
          next_s.bus.phase = ifcm_pkg::PH_TOKEN;
          next_s.slot_cnt  = '0;
        end
      end
      ifcm_pkg::PH_TOKEN: begin
        if (slot_end) begin
          // hand the token on, or keep it
          next_s.bus.token_peer = peer_master;
          next_s.bus.token_self = !peer_master;
          next_s.bus.phase      = ifcm_pkg::PH_RESERVE;
          next_s.slot_cnt       = '0;
        end
      end
      ifcm_pkg::PH_RESERVE: begin
        // active pause: token to ourselves until the cycle runs out
        if (slot_end) begin
          next_s.bus.token_self = 1'b1;
          next_s.slot_cnt       = '0;
        end
      end
      default: begin
        next_s.bus.phase = ifcm_pkg::PH_IDLE;
      end
    endcase
    // cycle boundary: a cycle still in exchange is cut and flagged
    if (s.bus.phase != ifcm_pkg::PH_IDLE && cyc_end) begin
      if (!s.exch_done) begin
        next_s.overrun = 1'b1;
      end
      go_start = run;
      if (!run) begin
        next_s.bus.phase = ifcm_pkg::PH_IDLE;
        next_s.sync_frame = 1'b0;
        next_s.acyc      = 1'b0;
        next_s.gap       = 1'b0;
      end
    end
    // new cycle: one strobe serves as bus and control clock
    if (go_start) begin
      next_s.strobe.cycle_start = 1'b1;
      next_s.cyc_cnt        = '0;
      next_s.slot_cnt       = '0;
      next_s.bus.phase      = ifcm_pkg::PH_SYNC;
      next_s.sync_frame     = 1'b1;
      next_s.acyc           = 1'b0;
      next_s.gap            = 1'b0;
      next_s.exch_done      = 1'b0;
      // pending setpoints ride this cycle's exchange
      next_s.bus.setpoints  = next_s.sp_pending;
      next_s.sp_pending     = setpoints_done;
    end
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s          <= '0;
      s.bus.phase <= ifcm_pkg::PH_IDLE;
      s.plc_role <= ifcm_pkg::ROLE_MASTER;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign plc_role    = s.plc_role;
  assign bus         = s.bus;
  assign sync_frame  = s.sync_frame;
  assign acyc_active = s.acyc;
  assign gap_active  = s.gap;
  assign strobe      = s.strobe;
  assign overrun     = s.overrun;
  assign order_fault = s.order_fault;
  // master role is wired, no path exists to make it a slave
  assign drive_role  = ifcm_pkg::ROLE_MASTER;

endmodule : ifcm_cycle_master

/* sim/ifcm_properties.sv */
// port checks of the cycle master
`timescale 1ns/1ps
`include "ifcm_cfg.svh"
module ifcm_properties (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   reset,
  // watched ports
  input wire ifcm_pkg::ifcm_cfg_t    cfg,
  input wire ifcm_pkg::ifcm_role_t   plc_role_sel,
  input wire ifcm_pkg::ifcm_role_t   drive_role,
  input wire ifcm_pkg::ifcm_role_t   plc_role,
  input wire ifcm_pkg::ifcm_bus_t    bus,
  input wire logic                   sync_frame,
  input wire logic                   acyc_active,
  input wire logic                   gap_active,
  input wire ifcm_pkg::ifcm_strobe_t strobe,
  input wire logic                   order_fault
);
  logic [15:0] cnt;  // cycles since the last cycle start, less one
  logic        seen; // a cycle start has passed, so cnt is meaningful
  // own cycle counter, restarted by each cycle start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt  <= 16'h0000;
      seen <= 1'b0;
    end else begin
      cnt  <= strobe.cycle_start ? 16'h0000 : cnt + 16'h0001;
      seen <= seen | strobe.cycle_start;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_drive_master: assert property (drive_role == ifcm_pkg::ROLE_MASTER)
    else $error("drive port left master role");
  a_plc_follow: assert property (!$past(reset) |-> plc_role == $past(plc_role_sel))
    else $error("plc role does not follow its select");
  a_sync_length: assert property ($rose(sync_frame) |-> ##79 sync_frame ##1 !sync_frame)
    else $error("sync broadcast length wrong");
  a_sync_each: assert property (strobe.cycle_start |-> sync_frame)
    else $error("cycle start without sync broadcast");
  a_cycle_period: assert property (strobe.cycle_start && seen |->
    cnt == cfg.bus_cycle_time - 16'h0001) else $error("cycle period wrong");
  a_latch_point: assert property (strobe.input_latch |->
    cnt == cfg.input_latch_instant) else $error("input latch strobe misplaced");
  a_accept_point: assert property (strobe.output_accept |->
    cnt == cfg.output_accept_instant) else $error("output accept strobe misplaced");
  a_ctrl_point: assert property (strobe.controller_start |->
    cnt == cfg.master_time && bus.phase != ifcm_pkg::PH_EXCH)
    else $error("controller start misplaced");
  a_acyc_limit: assert property ($rose(acyc_active) |->
    {1'b0, cnt} + 17'h000A0 < {1'b0, cfg.token_hold_limit})
    else $error("acyclic service past hold limit");
  a_gap_length: assert property ($rose(gap_active) |-> ##39 gap_active ##1 !gap_active)
    else $error("gap phase length wrong");
  a_token_pass: assert property ($rose(bus.phase == ifcm_pkg::PH_TOKEN) |->
    ##[0:20] (bus.token_self || bus.token_peer)) else $error("token not passed");
  // main scenarios reached
  c_acyc: cover property ($rose(acyc_active));
  c_peer: cover property (bus.token_peer);
  c_order: cover property ($rose(order_fault));
endmodule : ifcm_properties

bind ifcm_cycle_master ifcm_properties u_props (.clk, .reset, .cfg, .plc_role_sel,
  .drive_role, .plc_role, .bus, .sync_frame, .acyc_active, .gap_active, .strobe,
  .order_fault);

/* sim/ifcm_slave_model.sv */
// passive model of the slave drives on the drive bus
`timescale 1ns/1ps
`include "ifcm_cfg.svh"
module ifcm_slave_model (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // traffic and strobes from the master
  input  wire ifcm_pkg::ifcm_bus_t    bus,
  input  wire ifcm_pkg::ifcm_strobe_t strobe,
  // observations for the bench
  output logic [7:0]                  pairs,
  output logic [7:0]                  bad,
  output logic [15:0]                 actual
);
  ifcm_pkg::ifcm_seg_t last_seg;  // segment of the previous cycle
  logic                last_exch; // exchange was running
  logic [15:0]         own_clk;   // free-running slave cycle clock
  logic [15:0]         latched;   // actual value held for the next exchange
  logic                exch;      // exchange phase now
  assign exch = bus.phase == ifcm_pkg::PH_EXCH;
  // own clock reading at the latch instant, reported next exchange
  assign actual = latched;
  // the model never drives the bus; it only listens
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {pairs, bad, own_clk, latched, last_exch} <= '0;
      last_seg <= ifcm_pkg::SEG_HEADER;
    end else begin
      // keeps counting even if cycle starts stop
      own_clk   <= strobe.cycle_start ? 16'h0000 : own_clk + 16'h0001;
      last_exch <= exch;
      last_seg  <= bus.seg;
      if (strobe.input_latch) latched <= own_clk;
      if (strobe.cycle_start) pairs <= 8'h00;
      // segments must step header, parameter, process, trailer
      if (exch && last_exch && bus.seg != last_seg &&
          bus.seg != ifcm_pkg::ifcm_seg_t'(last_seg + 2'h1)) bad <= bad + 8'h01;
      // a reply trailer closes one request and reply pair
      if (exch && !bus.to_slave && bus.seg == ifcm_pkg::SEG_TRAILER &&
          last_seg != ifcm_pkg::SEG_TRAILER) pairs <= pairs + 8'h01;
    end
  end
endmodule : ifcm_slave_model

/* sim/tb.sv */
// self-checking bench of the cycle master
`timescale 1ns/1ps
`include "ifcm_cfg.svh"
module tb;
  logic clk = 1'b0, reset = 1'b1, run = 1'b0, acyc_req = 1'b0;
  logic peer_master = 1'b0, setpoints_done = 1'b0;
  ifcm_pkg::ifcm_cfg_t    cfg = '0;
  ifcm_pkg::ifcm_role_t   plc_role_sel = ifcm_pkg::ROLE_MASTER, drive_role, plc_role;
  ifcm_pkg::ifcm_bus_t    bus;
  ifcm_pkg::ifcm_strobe_t strobe;
  logic sync_frame, acyc_active, gap_active, overrun, order_fault;
  logic [7:0] pairs, bad;
  logic [15:0] actual;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  int per, lat, acc, ctl, n_self; // measured offsets from cycle start; n_self counts self token passes
  logic s_acyc, s_gap, s_peer, s_setp;
  always #25 clk = ~clk; // 20 MHz
  ifcm_cycle_master dut (.clk, .reset, .run, .cfg, .plc_role_sel, .acyc_req, .peer_master,
    .setpoints_done, .drive_role, .plc_role, .bus, .sync_frame, .acyc_active, .gap_active,
    .strobe, .overrun, .order_fault);
  ifcm_slave_model slaves (.clk, .reset, .bus, .strobe, .pairs, .bad, .actual);
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // hang guard, far above the longest run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // reset with a new setting, optional setpoint pulse in idle, then run
  task start(input logic [15:0] bct, mt, th, input logic sp, peer, acyc);
    reset = 1'b1;
    run = 1'b0;
    cfg = '{bct, mt, 16'h0064, 16'h0096, th};
    peer_master = peer;
    acyc_req = acyc;
    repeat (16) @(posedge clk);
    #5 reset = 1'b0;
    if (sp) begin
      @(posedge clk); #5 setpoints_done = 1'b1;
      @(posedge clk); #5 setpoints_done = 1'b0;
    end
    @(posedge clk); #5 run = 1'b1;
  endtask : start
  // watch one whole cycle, from one cycle start to the next
  task measure;
    int k;
    {per, lat, acc, ctl, n_self} = '0;
    {s_acyc, s_gap, s_peer, s_setp} = '0;
    for (k = 0; k < 100 && strobe.cycle_start !== 1'b1; k++) begin
      @(posedge clk); #5;
    end
    for (k = 1; k < 3000 && per == 0; k++) begin
      @(posedge clk); #5;
      if (strobe.input_latch === 1'b1) lat = k;
      if (strobe.output_accept === 1'b1) acc = k;
      if (strobe.controller_start === 1'b1) ctl = k;
      if (bus.token_self === 1'b1) n_self++;
      s_peer |= bus.token_peer === 1'b1;
      s_acyc |= acyc_active === 1'b1;
      s_gap |= gap_active === 1'b1;
      s_setp |= bus.setpoints === 1'b1 && bus.phase === ifcm_pkg::PH_EXCH;
      if (strobe.cycle_start === 1'b1) per = k;
    end
  endtask : measure
  task t_roles;
    start(16'h03E8, 16'h02BC, 16'h07D0, 1'b0, 1'b0, 1'b0);
    chk(drive_role, ifcm_pkg::ROLE_MASTER);
    plc_role_sel = ifcm_pkg::ROLE_SLAVE;
    repeat (2) @(posedge clk);
    #5 chk(plc_role, ifcm_pkg::ROLE_SLAVE);
    plc_role_sel = ifcm_pkg::ROLE_MASTER;
    repeat (2) @(posedge clk);
    #5 chk(plc_role, ifcm_pkg::ROLE_MASTER);
  endtask : t_roles
  task t_timing;
    start(16'h03E8, 16'h02BC, 16'h07D0, 1'b0, 1'b0, 1'b0);
    measure();
    chk(per, 32'h0000_03E8);
    chk(lat, 32'h0000_0065);
    chk(acc, 32'h0000_0097);
    chk(ctl, 32'h0000_02BD);
    chk(pairs, 8'h03);
    chk(overrun, 1'b0);
    chk(actual, 16'h0064);
    chk(bad, 0);
    chk({s_setp, s_gap, s_acyc, s_peer}, 4'h4);
    chk(n_self >= 2, 1);
  endtask : t_timing
  task t_acyc;
    start(16'h03E8, 16'h02BC, 16'h07D0, 1'b0, 1'b0, 1'b1);
    measure();
    chk(s_acyc, 1);
    start(16'h03E8, 16'h02BC, 16'h02BC, 1'b0, 1'b0, 1'b1);
    measure();
    chk(s_acyc, 0);
  endtask : t_acyc
  task t_peer_setp;
    start(16'h03E8, 16'h02BC, 16'h07D0, 1'b1, 1'b1, 1'b0);
    measure();
    chk(s_peer, 1);
    chk(s_setp, 1);
  endtask : t_peer_setp
  task t_order;
    start(16'h03E8, 16'h012C, 16'h07D0, 1'b0, 1'b0, 1'b0);
    measure();
    chk(ctl, 0);
    chk(order_fault, 1);
  endtask : t_order
  // cycle too short for the exchange: cut and flagged, then stopped by run
  task t_overrun;
    start(16'h01F4, 16'h01E0, 16'h07D0, 1'b0, 1'b0, 1'b0);
    measure();
    chk(per, 32'h0000_01F4);
    chk(overrun, 1'b1);
    run = 1'b0;
    repeat (16'h0258) @(posedge clk);
    #5 chk(bus.phase, ifcm_pkg::PH_IDLE);
    chk(sync_frame, 1'b0);
  endtask : t_overrun
  initial begin
    t_roles();
    t_timing();
    t_acyc();
    t_peer_setp();
    t_order();
    t_overrun();
    end_of_test();
  end
endmodule : tb
